// >>> src/spd_map.svh
// Constants for the serial packer and disconnect controller
`ifndef SPD_MAP_SVH
`define SPD_MAP_SVH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define SPD_OFF_CLOSE_CTL 8'h00
`define SPD_OFF_IDLE_TIME 8'h04
`define SPD_OFF_PKT_LEN 8'h08
`define SPD_OFF_DELIM 8'h0C
`define SPD_OFF_FLUSH_TIME 8'h10
`define SPD_OFF_STATUS 8'h14
`define SPD_OFF_COUNTS 8'h18
// ****************************************************************
// Field positions
// ****************************************************************
`define SPD_CTL_ENABLE_BIT 0
`define SPD_CTL_CHAR_LSB 8
`define SPD_DLM_D1_LSB 0
`define SPD_DLM_D2_LSB 8
`define SPD_DLM_MATCH1_BIT 16
`define SPD_DLM_PROC_LSB 20
// ****************************************************************
// Reset values and size limits
// ****************************************************************
`define SPD_RST_END_CHAR 8'h04
`define SPD_RST_MATCH1 1'b0
`define SPD_BUF_DEPTH 1024
`define SPD_MAX_PKT_LEN 11'h0400
// ****************************************************************
// Timing: one millisecond at 125 MHz
// ****************************************************************
`define SPD_CLK_HZ 125000000
`define SPD_TICK_MS 1
`define SPD_TICK_CYCLES ((`SPD_CLK_HZ / 1000) * `SPD_TICK_MS)
`define SPD_PROBE_MS 1000
`endif

// >>> src/spd_packer.sv
// Serial byte packer and TCP disconnect controller
// Function
// - Close connection on matching end character when end-character close is enabled.
// - End character is 8-bit configurable, default 04.
// - Idle disconnect time zero never closes on quiet line.
// - Idle time 1..65535 ms closes when no rx or tx serial data; the probe state clears the timer, so above 1000 ms it never idle-closes.
// - After idle close, return to listening state.
// - Probe remote periodically; close if probe goes unanswered.
// - Packet length zero means no length limit.
// - Packet length 1..1024 releases frame when count reaches it.
// - Delimiters are 8-bit; none defined forwards every byte at once.
// - With delimiters, hold bytes until delimiter arrives, then release.
// - Delimiter 2 zero means single char; both zero disables delimiting.
// - Full 1K buffer releases frame and empties buffer.
// - One-byte match releases on either delimiter value.
// - Two-byte match releases on delimiter 1 then delimiter 2.
// - Post-delimiter handling needs delimiter 1; with both in two-byte match, after both.
// - Release at delimiter, or after one or two extra bytes.
// - Flush timeout zero disables time-based flush.
// - Flush timeout 1..65535 ms releases when no byte arrives.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "spd_map.svh"
module spd_packer
  import spd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire spd_byte_s i_rx,
  input wire logic i_tx_act,
  input wire logic i_conn_up,
  input wire logic i_probe_ack,
  output spd_byte_s o_net,
  output spd_frame_s o_frame,
  output logic o_close,
  output logic o_listen,
  output logic o_probe
);
  // ****************************************************************
  // Configuration registers, byte buffer, counters and connection state
  // ****************************************************************
  logic end_char_close_enable_r;
  logic [7:0] end_char_value_r;
  logic [15:0] idle_time_r;
  logic [10:0] pkt_len_r;
  logic [7:0] delim1_r;
  logic [7:0] delim2_r;
  logic match1_r;
  logic [1:0] proc_r;
  logic [15:0] flush_time_r;
  logic [10:0] count_r;
  logic [7:0] buf_mem [0:`SPD_BUF_DEPTH-1];
  logic [31:0] frames_r;
  logic [31:0] closes_r;
  spd_conn_e conn_r;

  // Register writes
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      end_char_close_enable_r <= 1'b0;
      end_char_value_r <= `SPD_RST_END_CHAR;
      idle_time_r <= 16'h0000;
      pkt_len_r <= 11'h000;
      delim1_r <= 8'h00;
      delim2_r <= 8'h00;
      match1_r <= `SPD_RST_MATCH1;
      proc_r <= 2'h0;
      flush_time_r <= 16'h0000;
    end else if (i_wr) begin
      case (i_addr)
        `SPD_OFF_CLOSE_CTL: begin
          end_char_close_enable_r <= i_wdata[`SPD_CTL_ENABLE_BIT];
          end_char_value_r <= i_wdata[`SPD_CTL_CHAR_LSB +: 8];
        end
        `SPD_OFF_IDLE_TIME: idle_time_r <= i_wdata[15:0];
        `SPD_OFF_PKT_LEN: begin
          // Values above 1024 clip to the buffer size
          if (i_wdata > 32'(`SPD_MAX_PKT_LEN)) begin
            pkt_len_r <= `SPD_MAX_PKT_LEN;
          end else begin
            pkt_len_r <= i_wdata[10:0];
          end
        end
        `SPD_OFF_DELIM: begin
          delim1_r <= i_wdata[`SPD_DLM_D1_LSB +: 8];
          delim2_r <= i_wdata[`SPD_DLM_D2_LSB +: 8];
          match1_r <= i_wdata[`SPD_DLM_MATCH1_BIT];
          proc_r <= i_wdata[`SPD_DLM_PROC_LSB +: 2];
        end
        `SPD_OFF_FLUSH_TIME: flush_time_r <= i_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `SPD_OFF_CLOSE_CTL: o_rdata <= {16'h0000, end_char_value_r, 7'h00,
                                        end_char_close_enable_r};
        `SPD_OFF_IDLE_TIME: o_rdata <= {16'h0000, idle_time_r};
        `SPD_OFF_PKT_LEN: o_rdata <= {21'h00_0000, pkt_len_r};
        `SPD_OFF_DELIM: o_rdata <= {10'h000, proc_r, 3'h0, match1_r, delim2_r, delim1_r};
        `SPD_OFF_FLUSH_TIME: o_rdata <= {16'h0000, flush_time_r};
        `SPD_OFF_STATUS: o_rdata <= {17'h0_0000, count_r, conn_r};
        `SPD_OFF_COUNTS: o_rdata <= {frames_r[15:0], closes_r[15:0]};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  logic [16:0] tick_cnt_r;
  logic tick_ms;
  assign tick_ms = (tick_cnt_r == 17'(`SPD_TICK_CYCLES - 1));

  // Divider producing a one-cycle pulse each millisecond
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_r <= 17'h0_0000;
    end else if (tick_ms) begin
      tick_cnt_r <= 17'h0_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h0_0001;
    end
  end

  // ****************************************************************
  // Delimiter match and release decision
  // ****************************************************************
  logic d1_on;
  logic d2_on;
  logic dlm_on;
  logic prev_d1_r;
  logic dlm_hit;
  logic [1:0] post_cnt_r;
  logic post_arm_r;
  logic post_done;
  logic len_hit;
  logic full_hit;
  logic flush_hit;
  logic release_now;
  logic [10:0] count_inc;
  logic [15:0] flush_ms_r;

  assign d1_on = (delim1_r != 8'h00);
  assign d2_on = (delim2_r != 8'h00);
  assign dlm_on = d1_on || d2_on;
  assign count_inc = count_r + 11'h001;

  // Match on the current byte
  always_comb begin
    dlm_hit = 1'b0;
    if (i_rx.valid && dlm_on) begin
      if (!d2_on) begin
        dlm_hit = (i_rx.data == delim1_r);
      end else if (!d1_on) begin
        dlm_hit = (i_rx.data == delim2_r);
      end else if (match1_r) begin
        dlm_hit = (i_rx.data == delim1_r) || (i_rx.data == delim2_r);
      end else begin
        dlm_hit = prev_d1_r && (i_rx.data == delim2_r);
      end
    end
  end

  // Trailing byte counter after the delimiter
  assign post_done = post_arm_r && i_rx.valid && (post_cnt_r == 2'h1);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_d1_r <= 1'b0;
      post_arm_r <= 1'b0;
      post_cnt_r <= 2'h0;
    end else if (i_rx.valid) begin
      prev_d1_r <= (i_rx.data == delim1_r);
      if (post_arm_r) begin
        post_cnt_r <= post_cnt_r - 2'h1;
        if (post_cnt_r == 2'h1) begin
          post_arm_r <= 1'b0;
        end
      end else if (dlm_hit && d1_on && (proc_r == 2'h1 || proc_r == 2'h2)) begin
        post_arm_r <= 1'b1;
        post_cnt_r <= proc_r;
      end
    end else if (release_now) begin
      post_arm_r <= 1'b0;
    end
  end

  assign len_hit = i_rx.valid && (pkt_len_r != 11'h000) && (count_inc >= pkt_len_r);
  assign full_hit = i_rx.valid && (count_inc == 11'(`SPD_BUF_DEPTH));
  assign flush_hit = (flush_time_r != 16'h0000) && (count_r != 11'h000) && tick_ms &&
                     (flush_ms_r + 16'h0001 >= flush_time_r) && !i_rx.valid;

  // Release decision from all sources
  always_comb begin
    release_now = len_hit || full_hit || flush_hit || post_done;
    if (i_rx.valid && !dlm_on) begin
      release_now = 1'b1;
    end
    if (dlm_hit && !(d1_on && (proc_r == 2'h1 || proc_r == 2'h2))) begin
      release_now = 1'b1;
    end
  end

  // Quiet-line timer for the flush timeout; zero disables it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flush_ms_r <= 16'h0000;
    end else if (i_rx.valid || release_now || flush_time_r == 16'h0000) begin
      flush_ms_r <= 16'h0000;
    end else if (tick_ms) begin
      flush_ms_r <= flush_ms_r + 16'h0001;
    end
  end

  // ****************************************************************
  // Buffer, byte stream to network and frame marker
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rx.valid) begin
      buf_mem[count_r[9:0]] <= i_rx.data;
    end
  end

  // Byte count; a release empties the buffer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_r <= 11'h000;
    end else if (release_now) begin
      count_r <= 11'h000;
    end else if (i_rx.valid) begin
      count_r <= count_inc;
    end
  end

  // Bytes pass to the network side as they are buffered
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_net <= '0;
    end else begin
      o_net <= i_rx;
    end
  end

  // Frame end marker with length, one cycle after the closing byte
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_frame <= '0;
      frames_r <= 32'h0000_0000;
    end else begin
      o_frame.valid <= release_now;
      o_frame.len <= i_rx.valid ? count_inc : count_r;
      if (release_now) begin
        frames_r <= frames_r + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Connection control
  // ****************************************************************
  logic [15:0] idle_ms_r;
  logic [15:0] probe_ms_r;
  logic eot_hit;
  logic idle_hit;

  assign eot_hit = end_char_close_enable_r && i_rx.valid &&
                   (i_rx.data == end_char_value_r);
  assign idle_hit = (idle_time_r != 16'h0000) && tick_ms &&
                    (idle_ms_r + 16'h0001 >= idle_time_r);

  // Quiet-line timer for idle disconnect; rx and tx both restart it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      idle_ms_r <= 16'h0000;
    end else if (i_rx.valid || i_tx_act || conn_r != SPD_ST_OPEN) begin
      idle_ms_r <= 16'h0000;
    end else if (tick_ms) begin
      idle_ms_r <= idle_ms_r + 16'h0001;
    end
  end

  // Probe interval timer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      probe_ms_r <= 16'h0000;
    end else if (conn_r != SPD_ST_OPEN && conn_r != SPD_ST_PROBE) begin
      probe_ms_r <= 16'h0000;
    end else if (tick_ms) begin
      if (probe_ms_r == 16'(`SPD_PROBE_MS - 1)) begin
        probe_ms_r <= 16'h0000;
      end else begin
        probe_ms_r <= probe_ms_r + 16'h0001;
      end
    end
  end

  // Connection state machine
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conn_r <= SPD_ST_LISTEN;
      closes_r <= 32'h0000_0000;
    end else begin
      case (conn_r)
        SPD_ST_LISTEN: begin
          if (i_conn_up) begin
            conn_r <= SPD_ST_OPEN;
          end
        end
        SPD_ST_OPEN: begin
          if (eot_hit || idle_hit || !i_conn_up) begin
            conn_r <= SPD_ST_CLOSE;
          end else if (tick_ms && probe_ms_r == 16'(`SPD_PROBE_MS - 1)) begin
            conn_r <= SPD_ST_PROBE;
          end
        end
        SPD_ST_PROBE: begin
          if (eot_hit || idle_hit || !i_conn_up) begin
            conn_r <= SPD_ST_CLOSE;
          end else if (i_probe_ack) begin
            conn_r <= SPD_ST_OPEN;
          end else if (tick_ms && probe_ms_r == 16'(`SPD_PROBE_MS - 1)) begin
            conn_r <= SPD_ST_CLOSE;
          end
        end
        SPD_ST_CLOSE: begin
          conn_r <= SPD_ST_LISTEN;
          closes_r <= closes_r + 32'h0000_0001;
        end
        default: conn_r <= SPD_ST_LISTEN;
      endcase
    end
  end

  // Status outputs decoded from the state; the probe pulse also needs a tick with the probe timer at zero
  always_comb begin
    o_close = (conn_r == SPD_ST_CLOSE);
    o_listen = (conn_r == SPD_ST_LISTEN);
    o_probe = (conn_r == SPD_ST_PROBE) && (probe_ms_r == 16'h0000) && tick_ms;
  end
endmodule : spd_packer

// >>> src/spd_pkg.sv
// Types for the serial packer and disconnect controller
package spd_pkg;
  typedef enum logic [3:0] {
    SPD_ST_LISTEN = 4'b0001,
    SPD_ST_OPEN = 4'b0010,
    SPD_ST_PROBE = 4'b0100,
    SPD_ST_CLOSE = 4'b1000
  } spd_conn_e;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spd_byte_s;
  typedef struct packed {
    logic valid;
    logic [10:0] len;
  } spd_frame_s;
endpackage : spd_pkg

// >>> testbench/spd_host_model.sv
// Model of the host system that feeds serial bytes
`timescale 1ns/1ps
module spd_host_model
  import spd_pkg::*;
(
  input wire logic i_clk,
  output spd_byte_s o_rx
);
  logic [7:0] last_r;
  // Quiet line from time zero
  initial begin
    o_rx = '0;
    last_r = 8'h00;
  end
  // One byte per clock, held edge to edge
  task automatic send(input logic [7:0] b);
    o_rx <= '{valid: 1'b1, data: b};
    last_r <= b;
    @(posedge i_clk);
  endtask : send
  // Quiet line shows inverted data so a stale byte never passes
  task automatic idle();
    o_rx <= '{valid: 1'b0, data: ~last_r};
    @(posedge i_clk);
  endtask : idle
endmodule : spd_host_model

// >>> testbench/spd_packer_assertions.sv
// Port checker for the serial packer and disconnect controller
`timescale 1ns/1ps
module spd_packer_assertions
  import spd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire spd_byte_s i_rx,
  input wire logic i_conn_up,
  input wire spd_byte_s o_net,
  input wire spd_frame_s o_frame,
  input wire logic o_close,
  input wire logic o_listen,
  input wire logic o_probe
);
  // ****************************************************************
  // Shadow of the settings, so each check knows the active mode
  // ****************************************************************
  logic en_r;
  logic [7:0] ch_r;
  logic [15:0] dlm_r;
  logic [10:0] plen_r;
  // Follow bus writes; a long packet length clips to the buffer size
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_r <= 1'b0;
      ch_r <= 8'h04;
      dlm_r <= 16'h0000;
      plen_r <= 11'h000;
    end else if (i_wr && i_addr == 8'h00) begin
      en_r <= i_wdata[0];
      ch_r <= i_wdata[15:8];
    end else if (i_wr && i_addr == 8'h0c) begin
      dlm_r <= i_wdata[15:0];
    end else if (i_wr && i_addr == 8'h08) begin
      plen_r <= (i_wdata > 32'h0000_0400) ? 11'h400 : i_wdata[10:0];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  net_copy_a: assert property (
    i_rx.valid |=> o_net.valid && o_net.data == $past(i_rx.data))
    else $error("byte not forwarded");
  net_quiet_a: assert property (
    !i_rx.valid |=> !o_net.valid)
    else $error("byte forwarded without input");
  frame_each_a: assert property (
    i_rx.valid && dlm_r == 16'h0000 |=> o_frame.valid && o_frame.len == 11'h001)
    else $error("byte not sent alone");
  frame_cap_a: assert property (
    o_frame.valid |-> o_frame.len != 11'h000 && o_frame.len <= 11'h400)
    else $error("frame length out of range");
  frame_limit_a: assert property (
    o_frame.valid && plen_r != 11'h000 |-> o_frame.len <= plen_r)
    else $error("frame above packet length");
  end_close_a: assert property (
    i_rx.valid && en_r && i_rx.data == ch_r && !o_listen && !o_close |-> ##[1:2] o_close)
    else $error("end byte did not close");
  close_pulse_a: assert property (
    o_close |=> !o_close && o_listen)
    else $error("close not followed by listen");
  close_excl_a: assert property (
    o_close |-> !o_listen)
    else $error("close and listen together");
  listen_open_a: assert property (
    o_listen && i_conn_up |=> !o_listen)
    else $error("connection not taken");
  probe_pulse_a: assert property (
    o_probe |=> !o_probe)
    else $error("probe longer than one cycle");
  char_read_a: assert property (
    i_rd && i_addr == 8'h00 |=> o_rdata[15:8] == ch_r)
    else $error("end character readback wrong");
  rdata_quiet_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data without read");
  full_cov: cover property (o_frame.valid && o_frame.len == 11'h400);
  close_cov: cover property (o_close);
  multi_cov: cover property (o_frame.valid && o_frame.len > 11'h001);
endmodule : spd_packer_assertions
bind spd_packer spd_packer_assertions spd_packer_assertions_i (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_rx(i_rx), .i_conn_up(i_conn_up), .o_net(o_net), .o_frame(o_frame),
  .o_close(o_close), .o_listen(o_listen), .o_probe(o_probe));

// >>> testbench/spd_packer_test.sv
// Self-checking bench for the serial packer and disconnect controller
`timescale 1ns/1ps
module spd_packer_test import spd_pkg::*; ;
  logic i_clk, i_reset_n, i_wr, i_rd, i_tx_act, i_conn_up, i_probe_ack;
  logic o_close, o_listen, o_probe;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, got_f, got_n;
  spd_byte_s i_rx, o_net, ex_n;
  spd_frame_s o_frame, ex_f;
  int failures, cmp_count, plen, d1, d2, m1, post, cnt, prev, rem, nfr, closes, l;
  spd_packer spd_packer_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx(i_rx),
    .i_tx_act(i_tx_act), .i_conn_up(i_conn_up), .i_probe_ack(i_probe_ack), .o_net(o_net),
    .o_frame(o_frame), .o_close(o_close), .o_listen(o_listen), .o_probe(o_probe));
  spd_host_model spd_host_model_i (.i_clk(i_clk), .o_rx(i_rx));
  // 125 MHz clock
  always #4 i_clk = ~i_clk;
  // ****************************************************************
  // Reference packer: returns the frame length a byte closes, else 0
  // ****************************************************************
  function automatic int model_byte(input int b);
    int hit;
    int dl;
    hit = (d1 == 0 && d2 == 0);
    dl = 0;
    cnt++;
    if (!hit && rem > 0) begin
      rem--;
      hit = (rem == 0);
    end else if (!hit && (m1 != 0 || d1 == 0 || d2 == 0)) begin
      dl = (b == d1 && d1 != 0) || (b == d2 && d2 != 0);
    end else if (!hit) begin
      dl = (prev == d1 && b == d2);
    end
    // Trailing bytes count only with delimiter 1 set and a setting of 1 or 2
    if (dl && d1 != 0 && (post == 1 || post == 2)) begin
      rem = post;
    end else if (dl) begin
      hit = 1;
    end
    prev = b;
    if ((plen != 0 && cnt == plen) || cnt == 1024) hit = 1;
    model_byte = hit ? cnt : 0;
    if (hit) begin
      cnt = 0;
      rem = 0;
      prev = -1;
    end
  endfunction : model_byte
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    chk("read data", exp, o_rdata);
  endtask : rd
  task automatic cfg(input int ln, input int a, input int b, input int m, input int p);
    // Quiet line first, so the model is not reset under a byte in flight
    spd_host_model_i.idle();
    plen = ln;
    d1 = a;
    d2 = b;
    m1 = m;
    post = p;
    cnt = 0;
    prev = -1;
    rem = 0;
    wr(8'h08, 32'(ln));
    wr(8'h0c, 32'((p << 20) | (m << 16) | (b << 8) | a));
  endtask : cfg
  // Random printable bytes, never a delimiter or end character used here
  task automatic fill(input int n);
    for (int k = 0; k < n; k++) begin
      i_tx_act <= 1'($urandom % 2);
      i_probe_ack <= 1'($urandom % 2);
      spd_host_model_i.send(8'h20 + 8'($urandom % 95));
    end
  endtask : fill
  task automatic done(input string s);
    spd_host_model_i.idle();
    @(posedge i_clk);
    $display("test %s done", s);
  endtask : done
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  // Every cycle: compare outputs with the model, then feed it the byte taken
  always @(posedge i_clk) begin
    if (i_reset_n) begin
      // Length and data only count while their valid bit stands
      got_f = o_frame.valid ? {20'h0_0000, o_frame} : 32'h0000_0000;
      got_n = o_net.valid ? {23'h00_0000, o_net} : 32'h0000_0000;
      chk("frame", {20'h0_0000, ex_f}, got_f);
      chk("net", {23'h00_0000, ex_n}, got_n);
      chk("probe", 32'h0000_0000, {31'h0, o_probe});
      closes += (o_close === 1'b1);
      ex_n = i_rx.valid ? i_rx : '0;
      l = i_rx.valid ? model_byte(int'(i_rx.data)) : 0;
      nfr += (l != 0);
      ex_f = '{valid: l != 0, len: l[10:0]};
    end
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    $display("watchdog expired");
    complete_run();
  end
  // Main sequence; idle and flush timers stay at zero, so idle never
  // undercuts flush and no flush beats a character
  initial begin
    i_clk = 1'b0;
    i_reset_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_tx_act = 1'b0;
    i_conn_up = 1'b0;
    i_probe_ack = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    ex_n = '0;
    ex_f = '0;
    failures = 0;
    cmp_count = 0;
    nfr = 0;
    closes = 0;
    void'($urandom(67));
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    rd(8'h00, 32'h0000_0400);
    rd(8'h0c, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    rd(8'h14, 32'h0000_0001);
    done("reset values");
    cfg(0, 0, 0, 0, 0);
    fill(4);
    done("no delimiter");
    cfg(5, 8'hff, 0, 0, 0);
    fill(12);
    spd_host_model_i.send(8'hff);
    done("packet length");
    cfg(0, 8'h0d, 8'h0a, 0, 0);
    fill(3);
    spd_host_model_i.send(8'h0d);
    spd_host_model_i.send(8'h41);
    spd_host_model_i.send(8'h0a);
    spd_host_model_i.send(8'h0d);
    spd_host_model_i.send(8'h0a);
    done("two byte match");
    cfg(0, 8'h0d, 8'h0a, 1, 0);
    fill(2);
    spd_host_model_i.send(8'h0a);
    spd_host_model_i.send(8'h0d);
    done("one byte match");
    for (int p = 1; p < 3; p++) begin
      cfg(0, 8'h0d, 0, 0, p);
      fill(2);
      spd_host_model_i.send(8'h0d);
      fill(p);
    end
    done("post delimiter");
    cfg(0, 8'hff, 0, 0, 0);
    fill(1030);
    spd_host_model_i.send(8'hff);
    done("full buffer");
    wr(8'h08, 32'h0000_0fff);
    rd(8'h08, 32'h0000_0400);
    done("length clip");
    cfg(0, 0, 0, 0, 0);
    i_conn_up <= 1'b1;
    spd_host_model_i.send(8'h04);
    done("connect");
    rd(8'h14, 32'h0000_0002);
    wr(8'h00, 32'h0000_1b01);
    spd_host_model_i.send(8'h1b);
    done("end character");
    chk("closes", 32'h0000_0001, 32'(closes));
    i_conn_up <= 1'b0;
    done("drop");
    rd(8'h14, 32'h0000_0001);
    rd(8'h18, {16'(nfr), 16'h0002});
    complete_run();
  end
endmodule : spd_packer_test
